/* File: design/lvpdiv_top.v */
// top of the LVPECL channel dividers: register port, two dividers, two output pairs
//
// Notes on behaviour
// - low time is low field plus one
// - high time is high field plus one
// - bypass parks counters, passes input clock
// - divider 0 resets bypassed, divider 1 divides
// - nosync clear obeys sync, set ignores it
// - force level applies only with nosync set
// - start-level bit picks first waveform level
// - four-bit phase offset, control low nibble, reset zero
// - direct clear drives pair A from divider 0
// - direct set: 10b oscillator, 00b external, 01b none
// - pair B from divider 1, same direct rules
// - duty correction on unless disable bit set or divider bypassed
`timescale 1ns/1ps
`include "lvpdiv_defines.vh"
module lvpdiv_top (
    input  wire       clk_sys,
    input  wire       reset_n,
    input  wire [9:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrStrobe,
    input  wire       regRdStrobe,
    input  wire       syncHold,
    input  wire [1:0] srcSelect,
    input  wire       vcoClk,
    input  wire       extClk,
    output reg  [7:0] regRdData_q,
    output wire       pair_a_first_output,
    output wire       pair_a_second_output,
    output wire       pair_b_first_output,
    output wire       pair_b_second_output,
    output reg        dutyCorrectA_q,
    output reg        dutyCorrectB_q
);

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    reg  [7:0] div0Counts_q;
    reg  [7:0] div0Control_q;
    reg  [7:0] div0Path_q;
    reg  [7:0] div1Counts_q;
    reg  [7:0] div1Control_q;
    reg  [7:0] div1Path_q;
    reg  [7:0] rdData_d;

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            div0Counts_q  <= `LVPDIV_RST_COUNTS;
            div0Control_q <= `LVPDIV_RST_DIV0_CONTROL;
            div0Path_q    <= `LVPDIV_RST_PATH;
            div1Counts_q  <= `LVPDIV_RST_COUNTS;
            div1Control_q <= `LVPDIV_RST_DIV1_CONTROL;
            div1Path_q    <= `LVPDIV_RST_PATH;
        end else if (regWrStrobe) begin
            case (regAddr)
                `LVPDIV_OFS_DIV0_COUNTS:  div0Counts_q  <= regWrData;
                `LVPDIV_OFS_DIV0_CONTROL: div0Control_q <= regWrData;
                `LVPDIV_OFS_DIV0_PATH:    div0Path_q    <= regWrData & `LVPDIV_PATH_MASK;
                `LVPDIV_OFS_DIV1_COUNTS:  div1Counts_q  <= regWrData;
                `LVPDIV_OFS_DIV1_CONTROL: div1Control_q <= regWrData;
                `LVPDIV_OFS_DIV1_PATH:    div1Path_q    <= regWrData & `LVPDIV_PATH_MASK;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    always @* begin
        case (regAddr)
            `LVPDIV_OFS_DIV0_COUNTS:  rdData_d = div0Counts_q;
            `LVPDIV_OFS_DIV0_CONTROL: rdData_d = div0Control_q;
            `LVPDIV_OFS_DIV0_PATH:    rdData_d = div0Path_q;
            `LVPDIV_OFS_DIV1_COUNTS:  rdData_d = div1Counts_q;
            `LVPDIV_OFS_DIV1_CONTROL: rdData_d = div1Control_q;
            `LVPDIV_OFS_DIV1_PATH:    rdData_d = div1Path_q;
            default:                  rdData_d = `LVPDIV_RD_UNMAPPED;
        endcase
    end

    // data valid only in the cycle after the strobe, zero otherwise
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            regRdData_q <= 8'h00;
        end else begin
            regRdData_q <= regRdStrobe ? rdData_d : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // duty-correction enables to the analog correction cells
    // ---------------------------------------------------------------
    // a bypassed divider has no counter to correct, so the cell is kept off too
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            dutyCorrectA_q <= 1'b0;
            dutyCorrectB_q <= 1'b0;
        end else begin
            dutyCorrectA_q <= ~div0Path_q[`LVPDIV_BIT_DUTY_OFF] & ~div0Control_q[`LVPDIV_BIT_BYPASS];
            dutyCorrectB_q <= ~div1Path_q[`LVPDIV_BIT_DUTY_OFF] & ~div1Control_q[`LVPDIV_BIT_BYPASS];
        end
    end

    // ---------------------------------------------------------------
    // dividers
    // ---------------------------------------------------------------
    wire div0Level;
    wire div1Level;

    lvpdiv_divider u_div0 (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .lowCycles   (div0Counts_q[`LVPDIV_LOW_HI:`LVPDIV_LOW_LO]),
        .highCycles  (div0Counts_q[`LVPDIV_HIGH_HI:`LVPDIV_HIGH_LO]),
        .bypass      (div0Control_q[`LVPDIV_BIT_BYPASS]),
        .noSync      (div0Control_q[`LVPDIV_BIT_NOSYNC]),
        .startHigh   (div0Control_q[`LVPDIV_BIT_STARTHIGH]),
        .phaseOffset (div0Control_q[`LVPDIV_PHASE_HI:`LVPDIV_PHASE_LO]),
        .syncHold    (syncHold),
        .divLevel_q  (div0Level)
    );

    lvpdiv_divider u_div1 (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .lowCycles   (div1Counts_q[`LVPDIV_LOW_HI:`LVPDIV_LOW_LO]),
        .highCycles  (div1Counts_q[`LVPDIV_HIGH_HI:`LVPDIV_HIGH_LO]),
        .bypass      (div1Control_q[`LVPDIV_BIT_BYPASS]),
        .noSync      (div1Control_q[`LVPDIV_BIT_NOSYNC]),
        .startHigh   (div1Control_q[`LVPDIV_BIT_STARTHIGH]),
        .phaseOffset (div1Control_q[`LVPDIV_PHASE_HI:`LVPDIV_PHASE_LO]),
        .syncHold    (syncHold),
        .divLevel_q  (div1Level)
    );

    // ---------------------------------------------------------------
    // output pairs
    // ---------------------------------------------------------------
    lvpdiv_path_select u_pair_a (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .divLevel     (div0Level),
        .directPath   (div0Path_q[`LVPDIV_BIT_DIRECT]),
        .srcSelect    (srcSelect),
        .vcoClk       (vcoClk),
        .extClk       (extClk),
        .noSync       (div0Control_q[`LVPDIV_BIT_NOSYNC]),
        .forceHigh    (div0Control_q[`LVPDIV_BIT_FORCE]),
        .syncHold     (syncHold),
        .pairFirst_q  (pair_a_first_output),
        .pairSecond_q (pair_a_second_output)
    );

    lvpdiv_path_select u_pair_b (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .divLevel     (div1Level),
        .directPath   (div1Path_q[`LVPDIV_BIT_DIRECT]),
        .srcSelect    (srcSelect),
        .vcoClk       (vcoClk),
        .extClk       (extClk),
        .noSync       (div1Control_q[`LVPDIV_BIT_NOSYNC]),
        .forceHigh    (div1Control_q[`LVPDIV_BIT_FORCE]),
        .syncHold     (syncHold),
        .pairFirst_q  (pair_b_first_output),
        .pairSecond_q (pair_b_second_output)
    );

endmodule // lvpdiv_top

/* File: design/lvpdiv_defines.vh */
// register map, field positions, reset values and source codes for the LVPECL channel dividers
`ifndef LVPDIV_DEFINES_VH
`define LVPDIV_DEFINES_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LVPDIV_ADDR_W            10
`define LVPDIV_OFS_DIV0_COUNTS   10'h190
`define LVPDIV_OFS_DIV0_CONTROL  10'h191
`define LVPDIV_OFS_DIV0_PATH     10'h192
`define LVPDIV_OFS_DIV1_COUNTS   10'h196
`define LVPDIV_OFS_DIV1_CONTROL  10'h197
`define LVPDIV_OFS_DIV1_PATH     10'h198

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LVPDIV_LOW_HI            7
`define LVPDIV_LOW_LO            4
`define LVPDIV_HIGH_HI           3
`define LVPDIV_HIGH_LO           0
`define LVPDIV_BIT_BYPASS        7
`define LVPDIV_BIT_NOSYNC        6
`define LVPDIV_BIT_FORCE         5
`define LVPDIV_BIT_STARTHIGH     4
`define LVPDIV_PHASE_HI          3
`define LVPDIV_PHASE_LO          0
`define LVPDIV_BIT_DIRECT        1
`define LVPDIV_BIT_DUTY_OFF      0
`define LVPDIV_PATH_MASK         8'h03

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LVPDIV_RST_COUNTS        8'h00
`define LVPDIV_RST_DIV0_CONTROL  8'h80
`define LVPDIV_RST_DIV1_CONTROL  8'h00
`define LVPDIV_RST_PATH          8'h00
`define LVPDIV_RD_UNMAPPED       8'h00

// ---------------------------------------------------------------
// source-select codes for the direct path
// ---------------------------------------------------------------
`define LVPDIV_SRC_EXTCLK        2'h0
`define LVPDIV_SRC_NONE          2'h1
`define LVPDIV_SRC_VCO           2'h2

`endif

/* File: design/lvpdiv_divider.v */
// one LVPECL channel divider: high/low counting, bypass, sync hold and phase delay
`timescale 1ns/1ps
module lvpdiv_divider (
    input  wire       clk_sys,
    input  wire       reset_n,
    input  wire [3:0] lowCycles,
    input  wire [3:0] highCycles,
    input  wire       bypass,
    input  wire       noSync,
    input  wire       startHigh,
    input  wire [3:0] phaseOffset,
    input  wire       syncHold,
    output reg        divLevel_q
);

    reg  [3:0] count_q;
    reg  [3:0] delay_q;

    // ---------------------------------------------------------------
    // counting
    // ---------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            divLevel_q <= 1'b0;
            count_q    <= 4'h0;
            delay_q    <= 4'h0;
        end else if (bypass) begin
            // counters parked; output is the input clock image, one cycle high, one low
            divLevel_q <= ~divLevel_q;
            count_q    <= 4'h0;
            delay_q    <= 4'h0;
        end else if (syncHold && !noSync) begin
            // held at start level; reloading here makes the release edge deterministic
            divLevel_q <= startHigh;
            count_q    <= startHigh ? highCycles : lowCycles;
            delay_q    <= phaseOffset;
        end else if (delay_q != 4'h0) begin
            delay_q    <= delay_q - 4'h1;
        end else if (count_q == 4'h0) begin
            divLevel_q <= ~divLevel_q;
            count_q    <= divLevel_q ? lowCycles : highCycles;
        end else begin
            count_q    <= count_q - 4'h1;
        end
    end

endmodule // lvpdiv_divider

/* File: design/lvpdiv_path_select.v */
// output pair source selection: divider, oscillator or external clock, plus forced level
`timescale 1ns/1ps
`include "lvpdiv_defines.vh"
module lvpdiv_path_select (
    input  wire       clk_sys,
    input  wire       reset_n,
    input  wire       divLevel,
    input  wire       directPath,
    input  wire [1:0] srcSelect,
    input  wire       vcoClk,
    input  wire       extClk,
    input  wire       noSync,
    input  wire       forceHigh,
    input  wire       syncHold,
    output reg        pairFirst_q,
    output reg        pairSecond_q
);

    reg chosen;

    // ---------------------------------------------------------------
    // source mux
    // ---------------------------------------------------------------
    always @* begin
        // force only overrides while sync is ignored and sync is asserted
        chosen = (noSync && syncHold) ? forceHigh : divLevel;
        if (directPath) begin
            case (srcSelect)
                `LVPDIV_SRC_VCO:    chosen = vcoClk;
                `LVPDIV_SRC_EXTCLK: chosen = extClk;
                // other codes leave the divider path in place
                default:            ;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            pairFirst_q  <= 1'b0;
            pairSecond_q <= 1'b0;
        end else begin
            pairFirst_q  <= chosen;
            pairSecond_q <= chosen;
        end
    end

endmodule // lvpdiv_path_select

/* File: bench/lvpdiv_clk_source.sv */
// behavioural oscillator and external clock images feeding the dividers
`timescale 1ns/1ps
module lvpdiv_clk_source (
    input  wire  clk_sys,
    input  wire  reset_n,
    output logic vcoClk,
    output logic extClk
);
    logic [1:0] extCnt_q;
    initial {vcoClk, extClk, extCnt_q} = 4'h0;
    // external image three times slower, so it cannot pass for the oscillator
    always @(posedge clk_sys) begin
        vcoClk   <= reset_n & ~vcoClk;
        extCnt_q <= (!reset_n || extCnt_q == 2'h2) ? 2'h0 : extCnt_q + 2'h1;
        if (extCnt_q == 2'h2) extClk <= ~extClk;
    end
endmodule // lvpdiv_clk_source

/* File: bench/lvpdiv_props.sv */
// assertion checker for the channel divider top
`timescale 1ns/1ps
module lvpdiv_props (
    input wire       clk_sys,
    input wire       reset_n,
    input wire [9:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrStrobe,
    input wire       regRdStrobe,
    input wire       syncHold,
    input wire [1:0] srcSelect,
    input wire       vcoClk,
    input wire [7:0] regRdData_q,
    input wire       pair_a_first_output,
    input wire       pair_a_second_output,
    input wire       pair_b_first_output,
    input wire       pair_b_second_output,
    input wire       dutyCorrectB_q
);
    logic [7:0] ctlA_q;
    logic [7:0] ctlB_q;
    logic       dirA_q;
    logic       dccB_q;
    wire        dutyB = !dccB_q && !ctlB_q[7];
    // shadow control bytes, updated on the same edge as the design's
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ctlA_q <= 8'h80;
            ctlB_q <= 8'h00;
            dirA_q <= 1'b0;
            dccB_q <= 1'b0;
        end else if (regWrStrobe) begin
            if (regAddr == 10'h191) ctlA_q <= regWrData;
            if (regAddr == 10'h197) ctlB_q <= regWrData;
            if (regAddr == 10'h192) dirA_q <= regWrData[1];
            if (regAddr == 10'h198) dccB_q <= regWrData[0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    AST_PAIR_A: assert property (pair_a_first_output == pair_a_second_output)
        else $error("pair A split");
    AST_PAIR_B: assert property (pair_b_first_output == pair_b_second_output)
        else $error("pair B split");
    AST_RD_IDLE: assert property (!$past(regRdStrobe) |-> regRdData_q == 8'h00)
        else $error("stray read data");
    AST_RD_CTL: assert property (regRdStrobe && regAddr == 10'h191 |=> regRdData_q == $past(ctlA_q))
        else $error("control read wrong");
    AST_BYPASS: assert property (($past(reset_n) && ctlA_q[7] && !ctlA_q[6] && !dirA_q && !syncHold)[*3]
        |=> pair_a_first_output != $past(pair_a_first_output)) else $error("bypass not toggling");
    AST_DIRECT: assert property (
        dirA_q && srcSelect == 2'h2 && !syncHold |=> pair_a_first_output == $past(vcoClk))
        else $error("pair A not on oscillator");
    AST_FORCE: assert property (
        ctlA_q[6] && syncHold && !dirA_q |=> pair_a_first_output == $past(ctlA_q[5]))
        else $error("forced level missing");
    AST_DUTY: assert property ($past(reset_n) |-> dutyCorrectB_q == $past(dutyB))
        else $error("duty enable wrong");
    CV_DIRECT: cover property (dirA_q && srcSelect == 2'h2);
    CV_FORCE: cover property (ctlA_q[6] && syncHold);
    CV_HOLD: cover property (!ctlB_q[6] && $fell(syncHold));
endmodule // lvpdiv_props

bind lvpdiv_top lvpdiv_props u_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .syncHold(syncHold), .srcSelect(srcSelect),
    .vcoClk(vcoClk), .regRdData_q(regRdData_q), .pair_a_first_output(pair_a_first_output),
    .pair_a_second_output(pair_a_second_output), .pair_b_first_output(pair_b_first_output),
    .pair_b_second_output(pair_b_second_output), .dutyCorrectB_q(dutyCorrectB_q));

/* File: bench/testbench.sv */
// self-checking testbench for the channel dividers
`timescale 1ns/1ps
module testbench;
    logic       clk_sys = 1'b0;
    logic       reset_n = 1'b0;
    logic [9:0] regAddr = 10'h000;
    logic [7:0] regWrData = 8'h00;
    logic       regWrStrobe = 1'b0;
    logic       regRdStrobe = 1'b0;
    logic       syncHold = 1'b0;
    logic [1:0] srcSelect = 2'h1;
    logic       vcoClk, extClk, pairA, pairA2, pairB, pairB2, dutyA, dutyB;
    logic [7:0] regRdData_q, n0, n1;
    int         miscompares = 0;
    int         tests_run = 0;
    always #5 clk_sys = ~clk_sys;
    lvpdiv_clk_source src (.clk_sys(clk_sys), .reset_n(reset_n), .vcoClk(vcoClk), .extClk(extClk));
    lvpdiv_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .syncHold(syncHold), .srcSelect(srcSelect),
        .vcoClk(vcoClk), .extClk(extClk), .regRdData_q(regRdData_q), .pair_a_first_output(pairA),
        .pair_a_second_output(pairA2), .pair_b_first_output(pairB), .pair_b_second_output(pairB2),
        .dutyCorrectA_q(dutyA), .dutyCorrectB_q(dutyB));
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chkBit(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge clk_sys);
        regWrStrobe <= 1'b0;
    endtask
    task rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge clk_sys);
        regRdStrobe <= 1'b0;
        @(negedge clk_sys);
        chk(regRdData_q, exp);
    endtask
    // length of the current level run on one pair, counted at falling edges
    task runLen(input logic sel, output logic [7:0] n);
        logic lv;
        lv = sel ? pairB : pairA;
        n = 8'h00;
        while ((sel ? pairB : pairA) === lv && n < 8'h40) begin
            @(negedge clk_sys);
            n = n + 8'h01;
        end
    endtask
    task tBypass;
        logic prev;
        @(negedge clk_sys);
        chkBit(dutyA, 1'b0);
        chkBit(dutyB, 1'b1);
        repeat (6) begin
            prev = pairA;
            @(negedge clk_sys);
            chkBit(pairA, ~prev);
        end
    endtask
    task tReset;
        rd(10'h190, 8'h00);
        rd(10'h191, 8'h80);
        rd(10'h192, 8'h00);
        rd(10'h196, 8'h00);
        rd(10'h197, 8'h00);
        rd(10'h198, 8'h00);
        wr(10'h197, 8'h5A);
        rd(10'h197, 8'h5A);
        wr(10'h198, 8'hFF);
        rd(10'h198, 8'h03);
        chkBit(dutyB, 1'b0);
        wr(10'h194, 8'hFF);
        rd(10'h194, 8'h00);
        wr(10'h197, 8'h00);
        wr(10'h198, 8'h00);
    endtask
    task tDivide(input logic [7:0] c);
        logic lv;
        wr(10'h196, c);
        @(negedge clk_sys);
        repeat (2) runLen(1'b1, n0);
        repeat (2) begin
            lv = pairB;
            runLen(1'b1, n0);
            chk(n0, lv ? {4'h0, c[3:0]} + 8'h01 : {4'h0, c[7:4]} + 8'h01);
        end
    endtask
    task tHold(input logic s, input logic [3:0] p, output logic [7:0] n);
        wr(10'h197, {3'h0, s, p});
        syncHold <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chkBit(pairB, s);
        @(posedge clk_sys);
        syncHold <= 1'b0;
        @(negedge clk_sys);
        runLen(1'b1, n);
    endtask
    task tForce(input logic [7:0] c, input logic f);
        wr(10'h191, c);
        syncHold <= 1'b1;
        repeat (3) @(posedge clk_sys);
        repeat (2) begin
            @(negedge clk_sys);
            chkBit(pairA, f);
        end
        @(posedge clk_sys);
        syncHold <= 1'b0;
    endtask
    task tDirect(input logic sel, input logic [1:0] s);
        logic prev;
        @(posedge clk_sys);
        srcSelect <= s;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        if (s[0]) begin
            repeat (2) runLen(sel, n0);
            chk(n0, 8'h04);
        end else begin
            repeat (6) begin
                prev = s[1] ? vcoClk : extClk;
                @(negedge clk_sys);
                chkBit(sel ? pairB : pairA, prev);
            end
        end
    endtask
    task tPhase;
        tHold(1'b1, 4'h0, n0);
        chk(n0, 8'h11);
        tHold(1'b1, 4'h5, n1);
        chk(n1 - n0, 8'h05);
        tHold(1'b0, 4'h0, n1);
        chk(n1, 8'h02);
    endtask
    task tDuty;
        logic prev;
        @(negedge clk_sys);
        chkBit(dutyA, 1'b1);
        wr(10'h197, 8'h80);
        wr(10'h192, 8'h01);
        repeat (2) @(negedge clk_sys);
        chkBit(dutyA, 1'b0);
        chkBit(dutyB, 1'b0);
        repeat (4) begin
            prev = pairB;
            @(negedge clk_sys);
            chkBit(pairB, ~prev);
        end
        wr(10'h197, 8'h00);
    endtask
    task tPaths;
        wr(10'h190, 8'h33);
        wr(10'h196, 8'h33);
        wr(10'h192, 8'h02);
        wr(10'h198, 8'h02);
        for (int s = 0; s < 4; s++) begin
            tDirect(1'b0, s[1:0]);
            tDirect(1'b1, s[1:0]);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        conclude;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        tBypass;
        tReset;
        tDivide(8'h21);
        tDivide(8'h00);
        tDivide(8'hF0);
        tDivide(8'h0F);
        tPhase;
        tForce(8'h60, 1'b1);
        tForce(8'h40, 1'b0);
        tForce(8'h20, 1'b0);
        tDuty;
        tPaths;
        conclude;
    end
endmodule // testbench
